// >>> ucc_channel_control.sv
// sample fifo and the register bank of one upconverter channel
// assumes apb master on ref_clk; serial and sync pins are asynchronous
//
// Behaviour
// - each channel has a 32-bit tuning word split into low and high halves
// - a 16-bit phase offset is added to the accumulator output per channel
// - dither bit 15 set turns phase dither on, clear turns it off
// - meter-sync disable bit 12 blocks this channel's power meter sync only
// - channel runs only while enable bit 11 is set
// - mixer gain bit selects -6 dB when one, -12 dB when zero
// - ram-read bit 8 returns coefficient ram on the bus for unmapped reads, set only while reading
// - two 4-bit summing selects route A and B into output sums, any mix
// - 6-bit test select drives test bus; zero freezes its input data
// - 5-bit word length field holds bits per sample minus one
// - 0 to 3 bit clocks between frame strobe and sample msb
// - pin-mode bit 7 clear gives 2-pin mode, set gives 4-pin mode
// - frame strobe repeats every 7-bit interval of bit clocks, reset 50
// - bit clock is transmit clock divided by divider field plus one
// - 3-bit selector picks the pilot code generator sync source
// - one frame strobe serves the channel pair; source aligns both to it
//
// Local design decision: register access over APB.
`timescale 1ns/10ps

module ucc_fifo #(
  parameter int unsigned W     = 128,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wrPtr;
    logic [AW:0]             rdPtr;
  } ucc_fifo_s;
  ucc_fifo_s st;
  ucc_fifo_s next_st;
  logic full;
  logic empty;

  assign full = (st.wrPtr[AW] != st.rdPtr[AW]) && (st.wrPtr[AW-1:0] == st.rdPtr[AW-1:0]);
  assign empty = st.wrPtr == st.rdPtr;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = st.mem[st.rdPtr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (inValid && !full) begin
      next_st.mem[st.wrPtr[AW-1:0]] = inData;
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (outReady && !empty) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  property p_fifo_no_overrun;
    @(posedge ref_clk) disable iff (!resetn)
      full && !outReady |=> full;
  endproperty
  a_fifo_no_overrun: assert property (p_fifo_no_overrun) else $error("fifo lost its full state");
endmodule // ucc_fifo

module ucc_channel_control
  import ucc_pkg::*;
#(
  parameter int unsigned SAMPLE_W   = 32,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [3:0]            serialInPin,
  input  wire logic [3:0]            syncInPin,
  output logic                       frameStrobe,
  output logic                       sampleValid,
  input  wire logic                  sampleReady,
  output logic [4*SAMPLE_W-1:0]      sampleData,
  input  wire logic signed [17:0]    mixerIn,
  output logic signed [17:0]         mixerOut,
  input  wire logic [15:0]           coefRamData,
  output logic [IDX_W-1:0]           coefRamAddr,
  output logic                       coefRamRead,
  output logic [15:0]                ncoPhaseA,
  output logic [15:0]                ncoPhaseB,
  output logic                       ditherOn,
  output logic                       channelOn,
  output logic                       meterSync,
  output logic [3:0]                 sumSelA,
  output logic [3:0]                 sumSelB,
  output logic [2:0]                 pilotSyncSel,
  output logic                       pilotSync,
  output logic [5:0]                 testSel,
  output logic [15:0]                testBus
);
  typedef struct packed {
    logic [15:0]                pilot;
    logic [15:0]                freqALo;
    logic [15:0]                freqAHi;
    logic [15:0]                freqBLo;
    logic [15:0]                freqBHi;
    logic [15:0]                shiftA;
    logic [15:0]                shiftB;
    logic [15:0]                ctrl;
    logic [15:0]                tsel;
    logic [15:0]                fmt;
    logic [15:0]                div;
    logic                       overflow;
    logic [31:0]                rdData;
    logic [1:0][3:0]            pinSync;
    logic [1:0][3:0]            syncSync;
    logic [31:0]                accA;
    logic [31:0]                accB;
    logic [15:0]                lfsr;
    logic [15:0]                phaseA;
    logic [15:0]                phaseB;
    logic signed [17:0]         mix;
    logic [15:0]                testData;
    logic [3:0]                 divCnt;
    logic [6:0]                 frameCnt;
    logic                       strobe;
    ucc_ser_e                   ser;
    logic [4:0]                 bitCnt;
    logic                       iqHalf;
    logic [3:0][SAMPLE_W-1:0]   lane;
    logic [1:0][SAMPLE_W-1:0]   hold;
  } ucc_state_s;

  ucc_state_s st;
  ucc_state_s next_st;
  logic [IDX_W-1:0] idx;
  logic             mapped;
  logic             bitEn;
  logic             pushValid;
  logic             pushReady;
  logic [4*SAMPLE_W-1:0] pushData;
  logic [3:0]       serBit;
  logic [31:0]      freqA;
  logic [31:0]      freqB;

  function automatic logic isMapped(input logic [IDX_W-1:0] i);
    return (i == IDX_PILOT) || ((i >= IDX_FREQ_A_LO) && (i <= IDX_STATUS));
  endfunction

  function automatic logic [15:0] rdReg(input ucc_state_s s, input logic [IDX_W-1:0] i);
    logic [15:0] v;
    v = 16'h0000;
    if (i == IDX_PILOT) begin
      v = s.pilot;
    end else if (i == IDX_FREQ_A_LO) begin
      v = s.freqALo;
    end else if (i == IDX_FREQ_A_HI) begin
      v = s.freqAHi;
    end else if (i == IDX_FREQ_B_LO) begin
      v = s.freqBLo;
    end else if (i == IDX_FREQ_B_HI) begin
      v = s.freqBHi;
    end else if (i == IDX_SHIFT_A) begin
      v = s.shiftA;
    end else if (i == IDX_SHIFT_B) begin
      v = s.shiftB;
    end else if (i == IDX_CTRL) begin
      v = s.ctrl;
    end else if (i == IDX_TEST_SEL) begin
      v = s.tsel;
    end else if (i == IDX_SER_FMT) begin
      v = s.fmt;
    end else if (i == IDX_SER_DIV) begin
      v = s.div;
    end else if (i == IDX_STATUS) begin
      v = {15'h0000, s.overflow};
    end
    return v;
  endfunction

  assign idx = paddr[IDX_W+1:2];
  assign mapped = isMapped(idx);
  assign pready = 1'b1;
  // ram readback answers unmapped reads, so those are no error then
  assign pslverr = psel && penable && !mapped && (pwrite || !coefRamRead);
  assign prdata = st.rdData;
  assign coefRamAddr = idx;
  assign freqA = {st.freqAHi, st.freqALo};
  assign freqB = {st.freqBHi, st.freqBLo};
  assign bitEn = st.divCnt == st.div[3:0];
  assign serBit = st.pinSync[1];

  assign ditherOn = st.ctrl[CTL_DITHER];
  assign channelOn = st.ctrl[CTL_ENABLE];
  assign coefRamRead = st.ctrl[CTL_RAM_READ];
  assign sumSelA = st.ctrl[CTL_SUM_A +: 4];
  assign sumSelB = st.ctrl[CTL_SUM_B +: 4];
  assign pilotSyncSel = st.pilot[PILOT_SEL +: 3];
  assign testSel = st.tsel[5:0];
  assign ncoPhaseA = st.phaseA;
  assign ncoPhaseB = st.phaseB;
  assign mixerOut = st.mix;
  assign frameStrobe = st.strobe;
  assign meterSync = st.syncSync[1][0] && !st.ctrl[CTL_METER_OFF];
  // pilot sync pick; codes above three select no source
  assign pilotSync = !pilotSyncSel[2] && st.syncSync[1][pilotSyncSel[1:0]];
  assign testBus = (testSel == TSEL_ZERO) ? 16'h0000 : st.testData;

  assign pushValid = st.ser == SER_PUSH;
  assign pushData = st.fmt[FMT_PIN] ? {st.lane[3], st.lane[1], st.lane[2], st.lane[0]}
                                    : {st.lane[1], st.hold[1], st.lane[0], st.hold[0]};

  always_comb begin
    next_st = st;
    next_st.pinSync = {st.pinSync[0], serialInPin};
    next_st.syncSync = {st.syncSync[0], syncInPin};
    // read capture in the setup phase, register writes in the access phase
    if (psel && !penable) begin
      next_st.rdData = {16'h0000, rdReg(st, idx)};
      if (!mapped && coefRamRead) begin
        next_st.rdData = {16'h0000, coefRamData};
      end
    end
    if (psel && penable && pwrite) begin
      if (idx == IDX_PILOT) begin
        next_st.pilot = pwdata[15:0] & MASK_PILOT;
      end else if (idx == IDX_FREQ_A_LO) begin
        next_st.freqALo = pwdata[15:0];
      end else if (idx == IDX_FREQ_A_HI) begin
        next_st.freqAHi = pwdata[15:0];
      end else if (idx == IDX_FREQ_B_LO) begin
        next_st.freqBLo = pwdata[15:0];
      end else if (idx == IDX_FREQ_B_HI) begin
        next_st.freqBHi = pwdata[15:0];
      end else if (idx == IDX_SHIFT_A) begin
        next_st.shiftA = pwdata[15:0];
      end else if (idx == IDX_SHIFT_B) begin
        next_st.shiftB = pwdata[15:0];
      end else if (idx == IDX_CTRL) begin
        next_st.ctrl = pwdata[15:0] & MASK_CTRL;
      end else if (idx == IDX_TEST_SEL) begin
        next_st.tsel = pwdata[15:0] & MASK_TEST_SEL;
      end else if (idx == IDX_SER_FMT) begin
        next_st.fmt = pwdata[15:0] & MASK_SER_FMT;
      end else if (idx == IDX_SER_DIV) begin
        next_st.div = pwdata[15:0] & MASK_SER_DIV;
      end else if (idx == IDX_STATUS && pwdata[0]) begin
        next_st.overflow = 1'b0;
      end
    end
    next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
    if (channelOn) begin
      next_st.accA = st.accA + freqA;
      next_st.accB = st.accB + freqB;
    end else begin
      next_st.accA = 32'h0000_0000;
      next_st.accB = 32'h0000_0000;
    end
    next_st.phaseA = st.accA[31:16] + st.shiftA + {15'h0000, ditherOn & st.lfsr[0]};
    next_st.phaseB = st.accB[31:16] + st.shiftB + {15'h0000, ditherOn & st.lfsr[1]};
    if (!channelOn) begin
      next_st.mix = 18'sh00000;
    end else if (st.ctrl[CTL_MIX_GAIN]) begin
      next_st.mix = mixerIn >>> 1;
    end else begin
      next_st.mix = mixerIn >>> 2;
    end
    if (testSel == TSEL_PHASE_A) begin
      next_st.testData = st.phaseA;
    end else if (testSel == TSEL_PHASE_B) begin
      next_st.testData = st.phaseB;
    end else if (testSel == TSEL_ACC_A) begin
      next_st.testData = st.accA[31:16];
    end else if (testSel == TSEL_ACC_B) begin
      next_st.testData = st.accB[31:16];
    end
    next_st.divCnt = bitEn ? 4'h0 : st.divCnt + 4'h1;
    if (!channelOn) begin
      // preset so the first slot after enable strobes; no msb taken before a strobe
      next_st.frameCnt = 7'h7F;
      next_st.strobe = 1'b0;
      next_st.ser = SER_WAIT;
    end else if (bitEn) begin
      if ({1'b0, st.frameCnt} + 8'h01 >= {1'b0, st.fmt[FMT_INVL +: 7]}) begin
        next_st.frameCnt = 7'h00;
        next_st.strobe = 1'b1;
      end else begin
        next_st.frameCnt = st.frameCnt + 7'h01;
        next_st.strobe = 1'b0;
      end
      case (st.ser)
        SER_WAIT: begin
          // msb lands fsdel bit clocks after the strobe slot
          if (st.frameCnt == {5'h00, st.fmt[FMT_FSDEL +: 2]}) begin
            for (int i = 0; i < 4; i++) begin
              next_st.lane[i] = {{(SAMPLE_W-1){1'b0}}, serBit[i]};
            end
            next_st.bitCnt = 5'h00;
            next_st.iqHalf = 1'b0;
            next_st.ser = SER_SHIFT;
            if (st.fmt[FMT_BITS +: 5] == 5'h00) begin
              next_st.ser = st.fmt[FMT_PIN] ? SER_PUSH : SER_SHIFT;
            end
          end
        end
        SER_SHIFT: begin
          // msb first, bits field plus one per word
          if (st.bitCnt == st.fmt[FMT_BITS +: 5] && !st.fmt[FMT_PIN] && !st.iqHalf) begin
            next_st.hold = {st.lane[1], st.lane[0]};
            next_st.iqHalf = 1'b1;
            next_st.bitCnt = 5'h00;
            next_st.lane[0] = {{(SAMPLE_W-1){1'b0}}, serBit[0]};
            next_st.lane[1] = {{(SAMPLE_W-1){1'b0}}, serBit[1]};
            if (st.fmt[FMT_BITS +: 5] == 5'h00) begin
              next_st.ser = SER_PUSH;
            end
          end else begin
            for (int i = 0; i < 4; i++) begin
              next_st.lane[i] = {st.lane[i][SAMPLE_W-2:0], serBit[i]};
            end
            next_st.bitCnt = st.bitCnt + 5'h01;
            if (st.bitCnt + 5'h01 == st.fmt[FMT_BITS +: 5]) begin
              next_st.ser = (st.fmt[FMT_PIN] || st.iqHalf) ? SER_PUSH : SER_SHIFT;
            end
          end
        end
        SER_PUSH: begin
          // fifo stall: a missed msb slot is flagged
          if (!pushReady && st.frameCnt == {5'h00, st.fmt[FMT_FSDEL +: 2]}) begin
            next_st.overflow = 1'b1;
          end
        end
        default: next_st.ser = SER_WAIT;
      endcase
    end
    if (channelOn && st.ser == SER_PUSH && pushReady) begin
      next_st.ser = SER_WAIT;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.pilot <= RST_PILOT;
      st.ctrl <= RST_CTRL;
      st.tsel <= RST_TEST_SEL;
      st.fmt <= RST_SER_FMT;
      st.div <= RST_SER_DIV;
      st.freqALo <= RST_WORD;
      st.lfsr <= 16'h0001;
    end else begin
      st <= next_st;
    end
  end

  ucc_fifo #(
    .W     (4*SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (sampleValid),
    .outReady (sampleReady),
    .outData  (sampleData)
  );

  property p_acc_step;
    @(posedge ref_clk) disable iff (!resetn)
      channelOn ##1 channelOn |-> st.accA == $past(st.accA) + $past(freqA);
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator did not step by tuning word");
  property p_phase_sum;
    @(posedge ref_clk) disable iff (!resetn)
      !ditherOn ##1 1'b1 |-> st.phaseA == $past(st.accA[31:16]) + $past(st.shiftA);
  endproperty
  a_phase_sum: assert property (p_phase_sum) else $error("phase offset not applied");
  property p_dither_off;
    @(posedge ref_clk) disable iff (!resetn)
      !ditherOn ##1 !ditherOn |-> st.phaseB == $past(st.accB[31:16]) + $past(st.shiftB);
  endproperty
  a_dither_off: assert property (p_dither_off) else $error("dither active while off");
  property p_meter_block;
    @(posedge ref_clk) disable iff (!resetn)
      st.ctrl[CTL_METER_OFF] |-> !meterSync;
  endproperty
  a_meter_block: assert property (p_meter_block) else $error("meter sync passed while disabled");
  property p_off_idle;
    @(posedge ref_clk) disable iff (!resetn)
      !channelOn |=> st.accA == 32'h0000_0000 && !frameStrobe && st.ser == SER_WAIT;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("channel active while disabled");
  property p_mix_gain;
    @(posedge ref_clk) disable iff (!resetn)
      channelOn && !st.ctrl[CTL_MIX_GAIN] |=> mixerOut == ($past(mixerIn) >>> 2);
  endproperty
  a_mix_gain: assert property (p_mix_gain) else $error("mixer not at -12 dB");
  property p_ram_read;
    @(posedge ref_clk) disable iff (!resetn)
      psel && !penable && !pwrite && !mapped && coefRamRead |=> prdata == {16'h0000, $past(coefRamData)};
  endproperty
  a_ram_read: assert property (p_ram_read) else $error("ram readback missing");
  property p_test_zero;
    @(posedge ref_clk) disable iff (!resetn)
      testSel == TSEL_ZERO ##1 testSel == TSEL_ZERO |-> $stable(st.testData) && testBus == 16'h0000;
  endproperty
  a_test_zero: assert property (p_test_zero) else $error("test data moved while frozen");
  property p_slow_clock;
    @(posedge ref_clk) disable iff (!resetn)
      bitEn && st.div[3:0] == 4'hF && $stable(st.div) |=> !bitEn [*8];
  endproperty
  a_slow_clock: assert property (p_slow_clock) else $error("bit clock faster than divide by 16");
  property p_strobe_wrap;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(frameStrobe) |-> st.frameCnt == 7'h00;
  endproperty
  a_strobe_wrap: assert property (p_strobe_wrap) else $error("strobe off frame start");
endmodule // ucc_channel_control

// >>> ucc_pkg.sv
// constants of one upconverter channel's control set
// assumes 32-bit apb, word index = printed offset, byte address = 4 * index
package ucc_pkg;
  localparam int unsigned IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_PILOT = 8'h0B;
  localparam logic [IDX_W-1:0] IDX_FREQ_A_LO = 8'h13;
  localparam logic [IDX_W-1:0] IDX_FREQ_A_HI = 8'h14;
  localparam logic [IDX_W-1:0] IDX_FREQ_B_LO = 8'h15;
  localparam logic [IDX_W-1:0] IDX_FREQ_B_HI = 8'h16;
  localparam logic [IDX_W-1:0] IDX_SHIFT_A = 8'h17;
  localparam logic [IDX_W-1:0] IDX_SHIFT_B = 8'h18;
  localparam logic [IDX_W-1:0] IDX_CTRL = 8'h19;
  localparam logic [IDX_W-1:0] IDX_TEST_SEL = 8'h1A;
  localparam logic [IDX_W-1:0] IDX_SER_FMT = 8'h1B;
  localparam logic [IDX_W-1:0] IDX_SER_DIV = 8'h1C;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h1D;
  // channel_control fields
  localparam int unsigned CTL_DITHER = 15;
  localparam int unsigned CTL_TEST = 13;
  localparam int unsigned CTL_METER_OFF = 12;
  localparam int unsigned CTL_ENABLE = 11;
  localparam int unsigned CTL_MIX_GAIN = 9;
  localparam int unsigned CTL_RAM_READ = 8;
  localparam int unsigned CTL_SUM_B = 4;
  localparam int unsigned CTL_SUM_A = 0;
  // serial_format fields, then the pilot sync select field
  localparam int unsigned FMT_BITS = 11;
  localparam int unsigned FMT_FSDEL = 8;
  localparam int unsigned FMT_PIN = 7;
  localparam int unsigned FMT_INVL = 0;
  localparam int unsigned PILOT_SEL = 4;
  // writable bits and values after reset
  localparam logic [15:0] MASK_PILOT = 16'h0070;
  localparam logic [15:0] MASK_CTRL = 16'hFBFF;
  localparam logic [15:0] MASK_TEST_SEL = 16'h003F;
  localparam logic [15:0] MASK_SER_FMT = 16'hFBFF;
  localparam logic [15:0] MASK_SER_DIV = 16'h000F;
  localparam logic [15:0] RST_PILOT = 16'h0000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_CTRL = 16'h0021;
  localparam logic [15:0] RST_TEST_SEL = 16'h0000;
  localparam logic [15:0] RST_SER_FMT = 16'h8932;
  localparam logic [15:0] RST_SER_DIV = 16'h0001;
  // test bus selections
  localparam logic [5:0] TSEL_ZERO = 6'h00;
  localparam logic [5:0] TSEL_PHASE_A = 6'h01;
  localparam logic [5:0] TSEL_PHASE_B = 6'h02;
  localparam logic [5:0] TSEL_ACC_A = 6'h03;
  localparam logic [5:0] TSEL_ACC_B = 6'h04;
  typedef enum logic [1:0] {
    SER_WAIT  = 2'b00,
    SER_SHIFT = 2'b01,
    SER_PUSH  = 2'b11
  } ucc_ser_e;
endpackage

// >>> ucc_serial_source.sv
// baseband source model driving the four serial lines of one pair
// assumes frame delay 0 and a bit clock of ref_clk / (DIV + 1)
`timescale 1ns/10ps

module ucc_serial_source #(
  parameter int unsigned DIV = 3,
  parameter int unsigned W   = 4
) (
  input  wire logic           ref_clk,
  input  wire logic           frameStrobe,
  input  wire logic [4*W-1:0] laneWord,
  output logic [3:0]          serialInPin
);
  logic strobeD = 1'b0;
  logic active  = 1'b0;
  int   bitIdx  = 0;
  int   cnt     = 0;
  initial serialInPin = 4'h0;
  function automatic logic [3:0] pick(input int i);
    for (int l = 0; l < 4; l++) begin
      pick[l] = laneWord[l*W+i];
    end
  endfunction
  // all lanes on the shared strobe, msb first
  always @(posedge ref_clk) begin
    strobeD <= frameStrobe;
    if (frameStrobe && !strobeD) begin
      active <= 1'b1;
      bitIdx <= W - 1;
      cnt <= 0;
      serialInPin <= pick(W - 1);
    end else if (active && cnt == DIV) begin
      cnt <= 0;
      bitIdx <= bitIdx - 1;
      active <= (bitIdx != 0);
      serialInPin <= (bitIdx != 0) ? pick(bitIdx - 1) : ~serialInPin;
    end else if (active) begin
      cnt <= cnt + 1;
    end else begin
      // idle lines toggle so stale bits never look valid
      serialInPin <= ~serialInPin;
    end
  end
endmodule // ucc_serial_source

// >>> tb_upconverter_channel_control.sv
// self-checking bench for one upconverter channel control block
// assumes the serial source model feeds the serial pins
`timescale 1ns/10ps

module tb_upconverter_channel_control;
  import ucc_pkg::*;
  logic               ref_clk = 1'b0;
  logic               resetn = 1'b0;
  logic [11:0]        paddr = '0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = '0;
  logic [31:0]        prdata;
  logic               pready, pslverr, frameStrobe, sampleValid;
  logic [3:0]         serialInPin;
  logic [3:0]         syncInPin = 4'h1;
  logic               sampleReady = 1'b0;
  logic [127:0]       sampleData;
  logic signed [17:0] mixerIn = -18'sd100;
  logic signed [17:0] mixerOut;
  logic [15:0]        coefRamData = 16'hBEEF;
  logic [7:0]         coefRamAddr;
  logic               coefRamRead, ditherOn, channelOn, meterSync, pilotSync;
  logic [15:0]        ncoPhaseA, ncoPhaseB, testBus;
  logic [3:0]         sumSelA, sumSelB;
  logic [2:0]         pilotSyncSel;
  logic [5:0]         testSel;
  int                 nErrors = 0;
  int                 cmpCount = 0;
  int                 cycles = 0;
  localparam logic [127:0] EXP_SAMPLE = {32'h3, 32'h5, 32'hC, 32'hA};

  ucc_channel_control dut (.ref_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .serialInPin, .syncInPin, .frameStrobe, .sampleValid, .sampleReady,
    .sampleData, .mixerIn, .mixerOut, .coefRamData, .coefRamAddr, .coefRamRead, .ncoPhaseA,
    .ncoPhaseB, .ditherOn, .channelOn, .meterSync, .sumSelA, .sumSelB, .pilotSyncSel,
    .pilotSync, .testSel, .testBus);
  ucc_serial_source #(.DIV(3), .W(4)) src (.ref_clk, .frameStrobe, .laneWord(16'h3C5A),
    .serialInPin);

  always #5 ref_clk = ~ref_clk;

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, well beyond the roughly one thousand cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      nErrors++;
      wrapUp();
    end
  end

  task automatic chk(input logic [127:0] g, input logic [127:0] e, input string m);
    cmpCount++;
    if (g !== e) begin
      nErrors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk({er, rd}, {1'b0, e}, "register read");
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 6; i++) rdc(12'h04C + 12'(4 * i), 32'h0);
    rdc(12'h064, 32'h0000_0021);
    rdc(12'h06C, 32'h0000_8932);
    rdc(12'h070, 32'h0000_0001);
    rdc(12'h068, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic        er;
    for (int i = 0; i < 6; i++) wr(12'h04C + 12'(4 * i), 32'hFFFF_0000 | (32'h1111 * (i + 1)));
    for (int i = 0; i < 6; i++) rdc(12'h04C + 12'(4 * i), 32'h1111 * (i + 1));
    apb(1'b1, 12'h3FC, 32'h1, rd, er);
    chk(er, 1'b1, "unmapped write");
    $display("register access done");
  endtask

  task automatic t_ctrl();
    wr(12'h064, 32'h8A5A);
    settle();
    chk({ditherOn, channelOn, sumSelB, sumSelA, mixerOut}, {2'b11, 8'h5A, -18'sd50}, "gain 6");
    wr(12'h064, 32'h1800);
    settle();
    chk({ditherOn, meterSync, mixerOut}, {2'b00, -18'sd25}, "gain 12");
    wr(12'h064, 32'h0800);
    settle();
    chk(meterSync, 1'b1, "meter sync");
    wr(12'h064, 32'h0);
    settle();
    chk({channelOn, mixerOut, ncoPhaseA, ncoPhaseB}, {19'h0, 16'h5555, 16'h6666}, "off");
    wr(12'h02C, 32'h30);
    settle();
    chk({pilotSyncSel, pilotSync}, 4'h6, "pilot 3");
    wr(12'h02C, 32'h0);
    settle();
    chk({pilotSyncSel, pilotSync}, 4'h1, "pilot 0");
    $display("control bits done");
  endtask

  task automatic t_ram();
    logic [31:0] rd;
    logic        er;
    wr(12'h068, 32'h3F);
    wr(12'h064, 32'h0100);
    settle();
    chk({testSel, coefRamRead}, 7'h7F, "test select");
    apb(1'b0, 12'h3FC, 32'h0, rd, er);
    chk({er, rd, coefRamAddr}, {1'b0, 32'hBEEF, 8'hFF}, "ram read");
    wr(12'h064, 32'h0);
    wr(12'h068, 32'h0);
    apb(1'b0, 12'h3FC, 32'h0, rd, er);
    settle();
    chk({er, rd, testBus}, {1'b1, 48'h0}, "ram read off");
    $display("test modes done");
  endtask

  task automatic t_serial();
    int n;
    wr(12'h070, 32'h3);
    wr(12'h06C, 32'h1890);
    wr(12'h064, 32'h0800);
    n = 0;
    while (frameStrobe !== 1'b1 && n < 300) begin @(negedge ref_clk); n++; end
    n = 0;
    while (frameStrobe === 1'b1 && n < 50) begin @(negedge ref_clk); n++; end
    chk(n, 4, "strobe width");
    while (frameStrobe !== 1'b1 && n < 300) begin @(negedge ref_clk); n++; end
    chk(n, 64, "strobe interval");
    n = 0;
    while (sampleValid !== 1'b1 && n < 300) begin @(negedge ref_clk); n++; end
    chk(sampleData, EXP_SAMPLE, "sample");
    repeat (720) @(posedge ref_clk);
    wr(12'h064, 32'h0);
    rdc(12'h074, 32'h1);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      chk({sampleValid, sampleData}, {1'b1, EXP_SAMPLE}, "drain");
      @(posedge ref_clk) sampleReady <= 1'b1;
      @(posedge ref_clk) sampleReady <= 1'b0;
    end
    @(negedge ref_clk);
    chk(sampleValid, 1'b0, "empty");
    wr(12'h074, 32'h1);
    rdc(12'h074, 32'h0);
    wr(12'h070, 32'hF);
    wr(12'h064, 32'h0800);
    n = 0;
    while (frameStrobe !== 1'b1 && n < 300) begin @(negedge ref_clk); n++; end
    n = 0;
    while (frameStrobe === 1'b1 && n < 50) begin @(negedge ref_clk); n++; end
    chk(n, 16, "slow strobe width");
    wr(12'h064, 32'h0);
    $display("serial input done");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_ctrl();
    t_ram();
    t_serial();
    wrapUp();
  end
endmodule // tb_upconverter_channel_control
